// ### src/alpha_field_ucs2_decoder.sv
`timescale 1ns/10ps
module alpha_field_ucs2_decoder
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic in_valid,
   input wire logic [7:0] in_byte,
   input wire logic in_last,
   output logic in_ready,
   output logic out_valid,
   output logic [15:0] out_char,
   output logic out_last,
   output logic out_ucs2,
   input wire logic out_ready
);
   byte_stream_if #(.W(alpha_pkg::fifo_width)) fin ();
   byte_stream_if #(.W(alpha_pkg::fifo_width)) fout ();

   stream_fifo #(.W(alpha_pkg::fifo_width), .D(alpha_pkg::fifo_depth)) u_fifo
   (
      .clk(clk),
      .rst_b(rst_b),
      .wr(fin),
      .rd(fout)
   );

   assign fin.valid = in_valid;
   assign fin.data = {in_last, in_byte};
   assign in_ready = fin.ready;

   alpha_pkg::dec_state_e state_q;
   alpha_pkg::dec_state_e state_d;
   logic [7:0] count_q;
   logic [7:0] count_d;
   logic [15:0] base_q;
   logic [15:0] base_d;
   logic [7:0] hi_q;
   logic [7:0] hi_d;
   logic wide_q;
   logic wide_d;
   logic ovalid_q;
   logic [15:0] ochar_q;
   logic olast_q;
   logic oucs_q;

   wire [7:0] b = fout.data[7:0];
   wire blast = fout.data[8];
   wire out_free = !ovalid_q || out_ready;
   wire take = fout.valid && out_free;
   assign fout.ready = out_free;

   function automatic logic [15:0] half_char(input logic [7:0] c,
                                             input logic [15:0] base);
      if (c[alpha_pkg::top_bit])
         half_char = base + {9'h000, c[6:0]};
      else
         half_char = {9'h000, c[6:0]};
   endfunction

   logic emit;
   logic [15:0] echar;
   logic eucs;

   always_comb
   begin
      state_d = state_q;
      count_d = count_q;
      base_d = base_q;
      hi_d = hi_q;
      wide_d = wide_q;
      emit = 1'b0;
      echar = 16'h0000;
      eucs = 1'b0;
      if (take)
      begin
         case (state_q)
            alpha_pkg::st_lead:
               if (b == alpha_pkg::raw16_tag)
                  state_d = alpha_pkg::st_raw_hi;
               else if (b == alpha_pkg::half1_tag ||
                        b == alpha_pkg::half2_tag)
               begin
                  wide_d = (b == alpha_pkg::half2_tag);
                  state_d = alpha_pkg::st_count;
               end
               else
               begin
                  emit = 1'b1;
                  echar = {9'h000, b[6:0]};
               end
            alpha_pkg::st_count:
            begin
               count_d = b;
               state_d = alpha_pkg::st_base_hi;
            end
            alpha_pkg::st_base_hi:
               if (wide_q)
               begin
                  base_d = {b, 8'h00};
                  state_d = alpha_pkg::st_base_lo;
               end
               else
               begin
                  base_d = {1'b0, b, 7'h00} & alpha_pkg::half1_mask;
                  state_d = (count_q == 8'h00) ? alpha_pkg::st_skip
                          : alpha_pkg::st_chars;
               end
            alpha_pkg::st_base_lo:
            begin
               base_d = {base_q[15:8], b};
               state_d = (count_q == 8'h00) ? alpha_pkg::st_skip
                       : alpha_pkg::st_chars;
            end
            alpha_pkg::st_chars:
            begin
               emit = 1'b1;
               echar = half_char(b, base_q);
               eucs = b[alpha_pkg::top_bit];
               count_d = count_q - 8'h01;
               if (count_q == 8'h01)
                  state_d = alpha_pkg::st_skip;
            end
            alpha_pkg::st_raw_hi:
               hi_d = b;
            alpha_pkg::st_raw_lo:
               if (!(hi_q == alpha_pkg::fill_byte &&
                     b == alpha_pkg::fill_byte))
               begin
                  emit = 1'b1;
                  echar = {hi_q, b};
                  eucs = 1'b1;
               end
            alpha_pkg::st_skip:
               state_d = alpha_pkg::st_skip;
            default:
               state_d = alpha_pkg::st_lead;
         endcase
         if (state_q == alpha_pkg::st_raw_hi)
            state_d = alpha_pkg::st_raw_lo;
         else if (state_q == alpha_pkg::st_raw_lo)
            state_d = alpha_pkg::st_raw_hi;
         if (blast)
            state_d = alpha_pkg::st_lead;
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_q <= alpha_pkg::st_lead;
         count_q <= 8'h00;
         base_q <= 16'h0000;
         hi_q <= 8'h00;
         wide_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         count_q <= count_d;
         base_q <= base_d;
         hi_q <= hi_d;
         wide_q <= wide_d;
      end
   end

   // output holding register; a last byte with no character sets out_last with out_valid low
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ovalid_q <= 1'b0;
         ochar_q <= 16'h0000;
         olast_q <= 1'b0;
         oucs_q <= 1'b0;
      end
      else if (out_free)
      begin
         ovalid_q <= take && emit;
         ochar_q <= echar;
         olast_q <= take && blast;
         oucs_q <= eucs;
      end
   end

   assign out_valid = ovalid_q;
   assign out_char = ochar_q;
   assign out_last = olast_q;
   assign out_ucs2 = oucs_q;
endmodule // alpha_field_ucs2_decoder

// ### src/alpha_pkg.sv
package alpha_pkg;
   localparam logic [7:0] raw16_tag = 8'h80;
   localparam logic [7:0] half1_tag = 8'h81;
   localparam logic [7:0] half2_tag = 8'h82;
   localparam logic [7:0] fill_byte = 8'hff;
   localparam int fifo_width = 9;
   localparam int fifo_depth = 16;
   localparam int char_width = 16;
   localparam int top_bit = 7;
   localparam logic [15:0] half1_mask = 16'h7f80;
   typedef enum logic [2:0]
   {
      st_lead = 3'b000,
      st_count = 3'b001,
      st_base_hi = 3'b010,
      st_base_lo = 3'b011,
      st_chars = 3'b100,
      st_raw_hi = 3'b101,
      st_raw_lo = 3'b110,
      st_skip = 3'b111
   } dec_state_e;
endpackage

// ### src/byte_stream_if.sv
`timescale 1ns/10ps
interface byte_stream_if #(parameter int W = 9);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport source (output valid, output data, input ready);
   modport sink (input valid, input data, output ready);
endinterface

// ### src/stream_fifo.sv
`timescale 1ns/10ps
module stream_fifo #(parameter int W = 9, parameter int D = 16)
(
   input wire logic clk,
   input wire logic rst_b,
   byte_stream_if.sink wr,
   byte_stream_if.source rd
);
   localparam int aw = $clog2(D);
   logic [W-1:0] mem [D];
   logic [aw:0] wp_q;
   logic [aw:0] rp_q;
   wire full = (wp_q[aw] != rp_q[aw]) && (wp_q[aw-1:0] == rp_q[aw-1:0]);
   wire empty = (wp_q == rp_q);
   wire push = wr.valid && !full;
   wire pop = rd.ready && !empty;
   assign wr.ready = !full;
   assign rd.valid = !empty;
   assign rd.data = mem[rp_q[aw-1:0]];
   always_ff @(posedge clk)
   begin
      if (push)
         mem[wp_q[aw-1:0]] <= wr.data;
   end
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         wp_q <= '0;
         rp_q <= '0;
      end
      else
      begin
         if (push)
            wp_q <= wp_q + 1'b1;
         if (pop)
            rp_q <= rp_q + 1'b1;
      end
   end
endmodule // stream_fifo

// ### verif/alpha_asserts.sv
`timescale 1ns/10ps
module alpha_asserts
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic in_valid,
   input wire logic in_ready,
   input wire logic out_valid,
   input wire logic [15:0] out_char,
   input wire logic out_last,
   input wire logic out_ucs2,
   input wire logic out_ready
);
   logic [15:0] bal_q;
   logic hold;
   assign hold = out_valid & ~out_ready;
   // bytes taken minus characters accepted
   always_ff @(posedge clk or negedge rst_b)
      bal_q <= !rst_b ? 16'h0000 : bal_q + 16'(in_valid & in_ready)
         - 16'(out_valid & out_ready);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   a_valid_held: assert property (hold |=> out_valid)
      else $error("lost");
   a_char_held: assert property (hold |=> $stable(out_char))
      else $error("moved");
   a_flags_held: assert property (hold |=> $stable({out_last, out_ucs2}))
      else $error("flags");
   a_ascii_range: assert property (out_valid && !out_ucs2 |->
      out_char < 16'h0080) else $error("wide");
   a_no_surplus: assert property (out_valid |-> bal_q != 16'h0000)
      else $error("surplus");
   a_min_latency: assert property (bal_q == 16'h0000 |=> !out_valid)
      else $error("early");
   a_full_room: assert property (!in_ready |-> bal_q >= 16'h0010)
      else $error("full");
   a_full_cause: assert property ($fell(in_ready) |-> $past(in_valid))
      else $error("no push");
endmodule // alpha_asserts
bind alpha_field_ucs2_decoder alpha_asserts chk (.clk(clk), .rst_b(rst_b),
   .in_valid(in_valid), .in_ready(in_ready), .out_valid(out_valid),
   .out_char(out_char), .out_last(out_last), .out_ucs2(out_ucs2),
   .out_ready(out_ready));

// ### verif/char_sink.sv
`timescale 1ns/10ps
module char_sink
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [1:0] mode,
   output logic ready
);
   logic tick_q;
   always_ff @(posedge clk or negedge rst_b)
      tick_q <= !rst_b ? 1'h0 : !tick_q;
   // mode 0 prompt, 1 every other cycle, 2 stalled
   assign ready = mode == 2'h0 || (mode == 2'h1 && tick_q);
endmodule // char_sink

// ### verif/testbench.sv
`timescale 1ns/10ps
module testbench;
   logic clk = 1'h0, rst_b = 1'h0, in_valid = 1'h0, in_last = 1'h0;
   logic in_ready, out_valid, out_last, out_ucs2, out_ready;
   logic [1:0] mode = 2'h1;
   logic [7:0] in_byte = 8'h00;
   logic [15:0] out_char;
   logic [17:0] seen[$];
   int err_total = 0, samples_checked = 0;
   alpha_field_ucs2_decoder dut (.clk(clk), .rst_b(rst_b),
      .in_valid(in_valid), .in_byte(in_byte), .in_last(in_last),
      .in_ready(in_ready), .out_valid(out_valid), .out_char(out_char),
      .out_last(out_last), .out_ucs2(out_ucs2), .out_ready(out_ready));
   char_sink sink (.clk(clk), .rst_b(rst_b), .mode(mode), .ready(out_ready));
   initial forever #2 clk = ~clk;
   always @(posedge clk iff (out_valid === 1'h1 && out_ready === 1'h1))
      seen.push_back({out_last, out_ucs2, out_char});
   task report_and_stop;
      if (err_total == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task chk(input string what, input logic [17:0] exp, got);
      samples_checked++;
      err_total += int'(got !== exp);
      if (got !== exp)
         $display("MISMATCH %s exp %h got %h", what, exp, got);
   endtask
   // bytes go most significant first, last flag on the final one
   task run(input logic [255:0] b, input int nb, input logic [479:0] e,
      input int ne);
      for (int i = nb - 1; i >= 0; i--)
      begin
         in_valid <= 1'h1;
         {in_last, in_byte} <= {i == 0, b[8*i +: 8]};
         @(posedge clk iff in_ready === 1'h1);
      end
      in_valid <= 1'h0;
      for (int k = 0; k < 300 && seen.size() < ne; k++) @(posedge clk);
      for (int j = ne - 1; j >= 0; j--)
         chk("out_char", e[20*j +: 18], seen.pop_front());
      chk("extra", 18'h0, 18'(seen.size()));
   endtask
   task t_raw;
      run(64'h801234abcdffffff, 8, 40'h11234_1abcd, 2);
   endtask
   // count 3 drops the trailing 41; count 5 keeps it and marks the end
   task t_half;
      run(56'h8103135395ff41, 7, 60'h00053_10995_109ff, 3);
      run(56'h8105135395ff41, 7, 80'h00053_10995_109ff_20041, 4);
      run(32'h8101ff81, 4, 20'h37f81, 1);
      run(72'h820505302d82d32d31, 9, 100'h0002d_10532_10583_0002d_20031,
         5);
   endtask
   task t_full;
      mode <= 2'h2;
      fork
         run({12{16'h4142}}, 24, {{11{40'h00041_00042}}, 40'h00041_20042},
            24);
         begin
            repeat (40) @(posedge clk);
            chk("in_ready", 18'h0, 18'(in_ready));
            mode <= 2'h0;
         end
      join
   endtask
   initial
   begin
      repeat (20) @(posedge clk);
      rst_b <= 1'h1;
      t_raw;
      t_half;
      t_full;
      report_and_stop;
   end
   initial
   begin
      repeat (5000) @(posedge clk);
      err_total++;
      report_and_stop;
   end
endmodule // testbench
